/* File: design/exit_instruction_information.sv */
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module exit_instruction_information
   import vm_exit_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // exit event from the core
   input wire logic i_exit_valid,
   input wire logic [3:0] i_exit_kind,
   input wire logic [2:0] i_task_src,
   input wire logic i_deliv_sw,
   input wire logic i_injected,
   input wire logic [3:0] i_insn_len,
   // guest function call operands
   input wire logic [4:0] i_func_index,
   input wire logic [31:0] i_func_arg,
   input wire logic i_ptr_valid,
   // instruction operand description
   input wire logic [2:0] i_insn_id,
   input wire logic [2:0] i_addr_size,
   input wire logic [2:0] i_seg,
   input wire logic [1:0] i_scale,
   input wire logic [3:0] i_index_reg,
   input wire logic i_index_inv,
   input wire logic [3:0] i_base_reg,
   input wire logic i_base_inv,
   input wire logic [3:0] i_second_register_field,
   input wire logic i_op_size,
   // latched exit values
   output logic [3:0] o_exit_len,
   output logic o_exit_len_valid,
   output logic [31:0] o_exit_info,
   output logic o_exit_info_valid,
   output logic o_func_fail
);

   insn_fmt_if fmt ();

   logic [31:0] ctrl_ff;
   logic [31:0] func_en_ff;
   logic [3:0] entry_len_ff;
   logic [3:0] exit_len_ff;
   logic exit_len_valid_ff;
   logic [31:0] exit_info_ff;
   logic exit_info_valid_ff;
   logic func_fail_ff;
   logic inj_ff;
   logic [15:0] exit_cnt_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   logic take_exit;
   logic len_qual;
   logic func_failed;
   logic [3:0] nxt_len;
   logic nxt_len_valid;
   logic apb_access;
   logic apb_wr;
   logic apb_rd;
   logic addr_hit;
   logic [31:0] rd_word;

   // decode of a known register offset
   function automatic logic reg_known(input logic [7:0] addr);
      reg_known = (addr == OFF_CTRL) || (addr == OFF_FUNC_EN) ||
         (addr == OFF_EXIT_LEN) || (addr == OFF_EXIT_INFO) ||
         (addr == OFF_STATUS) || (addr == OFF_ENTRY_LEN);
   endfunction

   // does an exit of this kind measure the instruction length
   function automatic logic len_applies(
      input logic [3:0] kind,
      input logic [2:0] src,
      input logic deliv_sw,
      input logic fail
   );
      len_applies = 1'b0;
      unique case (kind)
         EXIT_INSN_FAULT: begin
            len_applies = 1'b1;
         end
         EXIT_INSN_TRAP: begin
            len_applies = 1'b0;
         end
         EXIT_SW_EXCEPTION: begin
            len_applies = 1'b1;
         end
         EXIT_DELIVERY_FAULT: begin
            len_applies = deliv_sw;
         end
         EXIT_TASK_SWITCH: begin
            if (src == TASK_SRC_CALL || src == TASK_SRC_INTERRUPT_RETURN ||
                  src == TASK_SRC_JMP) begin
               len_applies = 1'b1;
            end else if (src == TASK_SRC_GATE) begin
               len_applies = deliv_sw;
            end
         end
         EXIT_APIC_LINEAR: begin
            len_applies = deliv_sw;
         end
         EXIT_APIC_PHYSICAL: begin
            len_applies = 1'b0;
         end
         EXIT_FUNC_CALL: begin
            len_applies = fail;
         end
         default: begin
            len_applies = 1'b0;
         end
      endcase
   endfunction

   // failed guest function call check
   always_comb begin
      func_failed = 1'b0;
      if (!func_en_ff[i_func_index]) begin
         func_failed = 1'b1;
      end else if (i_func_index == 5'h00) begin
         func_failed = (i_func_arg >= FUNC_ARG_LIMIT) || !i_ptr_valid;
      end
   end

   assign take_exit = i_exit_valid && ctrl_ff[CTRL_CAPTURE_BIT];
   assign len_qual = len_applies(i_exit_kind, i_task_src, i_deliv_sw,
      func_failed);

   // length source: injected events other than instruction faults and function calls reuse the entry-time length
   always_comb begin
      nxt_len = 4'h0;
      nxt_len_valid = 1'b0;
      if (len_qual) begin
         if (i_injected && i_exit_kind != EXIT_FUNC_CALL &&
               i_exit_kind != EXIT_INSN_FAULT) begin
            nxt_len = entry_len_ff;
         end else begin
            nxt_len = i_insn_len;
         end
         nxt_len_valid = (nxt_len >= LEN_MIN) && (nxt_len <= LEN_MAX);
      end
   end

   // operand description to the formatter
   assign fmt.insn_id = insn_id_t'(i_insn_id);
   assign fmt.addr_size = i_addr_size;
   assign fmt.seg = i_seg;
   assign fmt.scale = i_scale;
   assign fmt.index_register_field = i_index_reg;
   assign fmt.index_inv = i_index_inv;
   assign fmt.base_register_field = i_base_reg;
   assign fmt.base_inv = i_base_inv;
   assign fmt.second_register_field = i_second_register_field;
   assign fmt.op_size = i_op_size;

   insn_info_fmt u_fmt (
      .fmt(fmt)
   );

   // apb decode
   assign apb_access = i_psel && i_penable && !pready_ff;
   assign addr_hit = reg_known(i_paddr);
   assign apb_wr = apb_access && i_pwrite && addr_hit;
   assign apb_rd = apb_access && !i_pwrite && addr_hit;

   always_comb begin
      rd_word = ZERO_WORD;
      unique case (i_paddr)
         OFF_CTRL: begin
            rd_word = ctrl_ff;
         end
         OFF_FUNC_EN: begin
            rd_word = func_en_ff;
         end
         OFF_EXIT_LEN: begin
            rd_word[3:0] = exit_len_ff;
            rd_word[LEN_VALID_BIT] = exit_len_valid_ff;
         end
         OFF_EXIT_INFO: begin
            rd_word = exit_info_ff;
         end
         OFF_STATUS: begin
            rd_word[15:0] = exit_cnt_ff;
            rd_word[STAT_FUNC_FAIL_BIT] = func_fail_ff;
            rd_word[STAT_INJ_BIT] = inj_ff;
         end
         OFF_ENTRY_LEN: begin
            rd_word[3:0] = entry_len_ff;
         end
         default: begin
            rd_word = ZERO_WORD;
         end
      endcase
   end

   // control register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_ff <= CTRL_RST;
      end else if (apb_wr && i_paddr == OFF_CTRL) begin
         ctrl_ff <= {31'h0000_0000, i_pwdata[CTRL_CAPTURE_BIT]};
      end
   end

   // guest function enable controls
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         func_en_ff <= FUNC_EN_RST;
      end else if (apb_wr && i_paddr == OFF_FUNC_EN) begin
         func_en_ff <= i_pwdata;
      end
   end

   // entry-time instruction length
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         entry_len_ff <= ENTRY_LEN_RST;
      end else if (apb_wr && i_paddr == OFF_ENTRY_LEN) begin
         entry_len_ff <= i_pwdata[3:0];
      end
   end

   // exit length capture, held until the next captured exit
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         exit_len_ff <= 4'h0;
         exit_len_valid_ff <= 1'b0;
      end else if (take_exit) begin
         exit_len_ff <= nxt_len;
         exit_len_valid_ff <= nxt_len_valid;
      end
   end

   // instruction-information capture
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         exit_info_ff <= ZERO_WORD;
         exit_info_valid_ff <= 1'b0;
      end else if (take_exit) begin
         exit_info_ff <= fmt.info;
         exit_info_valid_ff <= fmt.info_fmt_ok;
      end
   end

   // exit status
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         func_fail_ff <= 1'b0;
         inj_ff <= 1'b0;
         exit_cnt_ff <= 16'h0000;
      end else if (take_exit) begin
         func_fail_ff <= (i_exit_kind == EXIT_FUNC_CALL) && func_failed;
         inj_ff <= i_injected;
         exit_cnt_ff <= exit_cnt_ff + 16'h0001;
      end
   end

   // apb answer, one wait state
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= ZERO_WORD;
      end else begin
         pready_ff <= apb_access;
         pslverr_ff <= apb_access && !addr_hit;
         if (apb_rd) begin
            prdata_ff <= rd_word;
         end else if (apb_access) begin
            prdata_ff <= ZERO_WORD;
         end
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_exit_len = exit_len_ff;
   assign o_exit_len_valid = exit_len_valid_ff;
   assign o_exit_info = exit_info_ff;
   assign o_exit_info_valid = exit_info_valid_ff;
   assign o_func_fail = func_fail_ff;

endmodule

/* File: design/vm_exit_pkg.sv */
package vm_exit_pkg;

   // apb register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_FUNC_EN = 8'h04;
   localparam logic [7:0] OFF_EXIT_LEN = 8'h08;
   localparam logic [7:0] OFF_EXIT_INFO = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_ENTRY_LEN = 8'h14;

   // values after reset
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] FUNC_EN_RST = 32'h0000_0001;
   localparam logic [3:0] ENTRY_LEN_RST = 4'h0;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   // control, exit length and status field positions
   localparam int CTRL_CAPTURE_BIT = 0;
   localparam int LEN_VALID_BIT = 4;
   localparam int STAT_FUNC_FAIL_BIT = 16;
   localparam int STAT_INJ_BIT = 17;

   // length and function-call limits
   localparam logic [3:0] LEN_MIN = 4'h1;
   localparam logic [3:0] LEN_MAX = 4'hF;
   localparam logic [31:0] FUNC_ARG_LIMIT = 32'h0000_0200;

   // instruction-information field positions
   localparam int F_SCALE_LO = 0;
   localparam int F_ASIZE_LO = 7;
   localparam int F_ZERO_BIT = 10;
   localparam int F_OPSIZE_BIT = 11;
   localparam int F_SEG_LO = 15;
   localparam int F_IDX_LO = 18;
   localparam int F_IDX_INV_BIT = 22;
   localparam int F_BASE_LO = 23;
   localparam int F_BASE_INV_BIT = 27;
   localparam int F_SECOND_REGISTER_FIELD_LO = 28;

   typedef enum logic [3:0] {
      EXIT_INSN_FAULT = 4'b0000,
      EXIT_INSN_TRAP = 4'b0001,
      EXIT_SW_EXCEPTION = 4'b0010,
      EXIT_DELIVERY_FAULT = 4'b0011,
      EXIT_TASK_SWITCH = 4'b0100,
      EXIT_APIC_LINEAR = 4'b0101,
      EXIT_APIC_PHYSICAL = 4'b0110,
      EXIT_FUNC_CALL = 4'b0111,
      EXIT_OTHER = 4'b1000
   } exit_kind_t;

   typedef enum logic [2:0] {
      TASK_SRC_CALL = 3'b000,
      TASK_SRC_INTERRUPT_RETURN = 3'b001,
      TASK_SRC_JMP = 3'b010,
      TASK_SRC_GATE = 3'b011,
      TASK_SRC_OTHER = 3'b100
   } task_src_t;

   typedef enum logic [2:0] {
      INSN_PORT_STRING_INPUT = 3'b000,
      INSN_PORT_STRING_OUTPUT = 3'b001,
      INSN_EXT_PAGE_TABLE_FLUSH = 3'b010,
      INSN_CONTEXT_ID_FLUSH = 3'b011,
      INSN_VIRTUAL_PROC_ID_FLUSH = 3'b100,
      INSN_DESC_TABLE = 3'b101,
      INSN_OTHER = 3'b110
   } insn_id_t;

endpackage

/* File: design/insn_fmt_if.sv */
`timescale 1ns/100ps
interface insn_fmt_if;
   import vm_exit_pkg::*;
   insn_id_t insn_id;
   logic [2:0] addr_size;
   logic [2:0] seg;
   logic [1:0] scale;
   logic [3:0] index_register_field;
   logic index_inv;
   logic [3:0] base_register_field;
   logic base_inv;
   logic [3:0] second_register_field;
   logic op_size;
   logic info_fmt_ok;
   logic [31:0] info;

   modport producer (
      output insn_id, addr_size, seg, scale, index_register_field,
      output index_inv, base_register_field, base_inv,
      output second_register_field, op_size,
      input info_fmt_ok, info
   );
   modport formatter (
      input insn_id, addr_size, seg, scale, index_register_field,
      input index_inv, base_register_field, base_inv,
      input second_register_field, op_size,
      output info_fmt_ok, info
   );
endinterface

/* File: design/insn_info_fmt.sv */
`timescale 1ns/100ps
module insn_info_fmt
   import vm_exit_pkg::*;
(
   insn_fmt_if.formatter fmt
);

   // undefined bits are driven to zero
   always_comb begin
      fmt.info = ZERO_WORD;
      fmt.info_fmt_ok = 1'b1;
      unique case (fmt.insn_id)
         INSN_PORT_STRING_INPUT: begin
            fmt.info[F_ASIZE_LO +: 3] = fmt.addr_size;
         end
         INSN_PORT_STRING_OUTPUT: begin
            fmt.info[F_ASIZE_LO +: 3] = fmt.addr_size;
            fmt.info[F_SEG_LO +: 3] = fmt.seg;
         end
         INSN_EXT_PAGE_TABLE_FLUSH, INSN_CONTEXT_ID_FLUSH,
         INSN_VIRTUAL_PROC_ID_FLUSH, INSN_DESC_TABLE: begin
            if (!fmt.index_inv) begin
               fmt.info[F_SCALE_LO +: 2] = fmt.scale;
               fmt.info[F_IDX_LO +: 4] = fmt.index_register_field;
            end
            fmt.info[F_IDX_INV_BIT] = fmt.index_inv;
            fmt.info[F_ASIZE_LO +: 3] = fmt.addr_size;
            fmt.info[F_ZERO_BIT] = 1'b0;
            fmt.info[F_SEG_LO +: 3] = fmt.seg;
            if (!fmt.base_inv) begin
               fmt.info[F_BASE_LO +: 4] = fmt.base_register_field;
            end
            fmt.info[F_BASE_INV_BIT] = fmt.base_inv;
            if (fmt.insn_id == INSN_DESC_TABLE) begin
               fmt.info[F_OPSIZE_BIT] = fmt.op_size;
            end else begin
               fmt.info[F_SECOND_REGISTER_FIELD_LO +: 4] = fmt.second_register_field;
            end
         end
         INSN_OTHER: begin
            fmt.info_fmt_ok = 1'b0;
         end
         default: begin
            fmt.info_fmt_ok = 1'b0;
         end
      endcase
   end

endmodule

/* File: verification/vm_exit_checker.sv */
`timescale 1ns/100ps
module vm_exit_checker
   import vm_exit_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // apb
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   // exit event
   input wire logic i_exit_valid,
   input wire logic [3:0] i_exit_kind,
   input wire logic i_injected,
   input wire logic [3:0] i_insn_len,
   input wire logic [4:0] i_func_index,
   input wire logic [31:0] i_func_arg,
   // operands
   input wire logic [2:0] i_insn_id,
   input wire logic [2:0] i_addr_size,
   input wire logic [2:0] i_seg,
   input wire logic [1:0] i_scale,
   input wire logic [3:0] i_index_reg,
   input wire logic i_index_inv,
   input wire logic i_base_inv,
   input wire logic [3:0] i_second_register_field,
   input wire logic i_op_size,
   // results
   input wire logic [3:0] o_exit_len,
   input wire logic o_exit_len_valid,
   input wire logic [31:0] o_exit_info,
   input wire logic o_func_fail
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   logic cap_ff;
   logic take;
   logic flush;
   // mirror of the capture enable bit
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cap_ff <= 1'b1;
      end else if (i_psel && i_penable && !o_pready && i_pwrite
                   && i_paddr == OFF_CTRL) begin
         cap_ff <= i_pwdata[CTRL_CAPTURE_BIT];
      end
   end
   assign take = i_exit_valid && cap_ff;
   assign flush = i_insn_id inside {3'h2, 3'h3, 3'h4};
   hold_values_a: assert property (
      !take |=> $stable(o_exit_len) && $stable(o_exit_info)
         && $stable(o_exit_len_valid))
      else $error("exit values changed without an exit");
   fault_len_a: assert property (
      take && i_exit_kind == 4'h0 && i_insn_len != 4'h0
      |=> o_exit_len_valid && o_exit_len == $past(i_insn_len))
      else $error("fault exit length not recorded");
   trap_nolen_a: assert property (
      take && i_exit_kind == 4'h1 |=> !o_exit_len_valid)
      else $error("trap exit recorded a length");
   swexc_len_a: assert property (
      take && i_exit_kind == 4'h2 && !i_injected && i_insn_len != 4'h0
      |=> o_exit_len_valid && o_exit_len == $past(i_insn_len))
      else $error("software exception length wrong");
   phys_nolen_a: assert property (
      take && i_exit_kind == 4'h6 |=> !o_exit_len_valid)
      else $error("physical access exit recorded a length");
   func_fail_a: assert property (
      take && i_exit_kind == 4'h7 && i_func_index == 5'h00
      && i_func_arg >= FUNC_ARG_LIMIT |=> o_func_fail)
      else $error("function call argument limit missed");
   port_seg_a: assert property (
      take && i_insn_id == 3'h1 |=> o_exit_info[17:15] == $past(i_seg)
         && o_exit_info[9:7] == $past(i_addr_size))
      else $error("port output info fields wrong");
   flush_regs_a: assert property (
      take && flush |=> o_exit_info[10] == 1'b0
         && o_exit_info[31:28] == $past(i_second_register_field)
         && o_exit_info[9:7] == $past(i_addr_size))
      else $error("flush info size or register wrong");
   index_field_a: assert property (
      take && flush && !i_index_inv
      |=> o_exit_info[21:18] == $past(i_index_reg)
         && o_exit_info[1:0] == $past(i_scale) && !o_exit_info[22])
      else $error("index or scaling field wrong");
   inv_flags_a: assert property (
      take && flush |=> o_exit_info[27] == $past(i_base_inv)
         && o_exit_info[22] == $past(i_index_inv))
      else $error("invalid flags wrong");
   op_size_a: assert property (
      take && i_insn_id == 3'h5 |=> o_exit_info[11] == $past(i_op_size))
      else $error("operand size bit wrong");
endmodule
bind exit_instruction_information vm_exit_checker u_chk (.*);

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import vm_exit_pkg::*;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0000_0000, i_func_arg = 32'h0000_0000;
   logic i_exit_valid = 1'b0, i_deliv_sw = 1'b0, i_injected = 1'b0;
   logic i_ptr_valid = 1'b1, i_index_inv = 1'b0, i_base_inv = 1'b0;
   logic i_op_size = 1'b1;
   logic [3:0] i_exit_kind = 4'h0, i_insn_len = 4'h0, i_index_reg = 4'h9;
   logic [3:0] i_base_reg = 4'hC, i_second_register_field = 4'hF;
   logic [2:0] i_task_src = 3'h4, i_insn_id = 3'h0, i_addr_size = 3'h2;
   logic [2:0] i_seg = 3'h3;
   logic [1:0] i_scale = 2'h3;
   logic [4:0] i_func_index = 5'h00;
   logic [31:0] o_prdata, o_exit_info, rd;
   logic o_pready, o_pslverr, o_exit_len_valid, o_exit_info_valid;
   logic o_func_fail, er;
   logic [3:0] o_exit_len;
   int err_total = 0;
   int n_checks = 0;

   exit_instruction_information dut (.*);

   always #25 i_clk = ~i_clk;

   task automatic end_sim;
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic ck_len(input logic v, input logic [3:0] l);
      chk({27'h0, o_exit_len_valid, o_exit_len}, {27'h0, v, l});
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 20) begin
         err_total++;
         $display("unexpected at %0t: no bus answer", $time);
      end
   endtask

   // pulse one exit; returns on the edge after it is taken
   task automatic ex(input logic [3:0] k, input logic [3:0] len);
      @(posedge i_clk);
      i_exit_kind <= k;
      i_insn_len <= len;
      i_exit_valid <= 1'b1;
      @(posedge i_clk);
      i_exit_valid <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic t_regs;
      apb(1'b0, OFF_CTRL, ZERO_WORD);
      chk(rd, CTRL_RST);
      apb(1'b0, OFF_FUNC_EN, ZERO_WORD);
      chk(rd, FUNC_EN_RST);
      apb(1'b0, OFF_ENTRY_LEN, ZERO_WORD);
      chk(rd, ZERO_WORD);
      apb(1'b1, OFF_EXIT_INFO, 32'hFFFF_FFFF);
      apb(1'b0, OFF_EXIT_INFO, ZERO_WORD);
      chk({rd[31:1], er}, ZERO_WORD);
      apb(1'b0, 8'h1C, ZERO_WORD);
      chk({rd[31:1], er}, 32'h0000_0001);
   endtask

   // kind, source, software delivery, length, recorded
   task automatic t_len;
      logic [19:0] tab [13] = '{20'h0_4051, 20'h0_4000, 20'h1_4050,
         20'h2_4011, 20'h3_41F1, 20'h4_0071, 20'h4_1071, 20'h4_2071,
         20'h4_3171, 20'h4_4070, 20'h5_4131, 20'h6_4130, 20'h8_4030};
      foreach (tab[i]) begin
         i_task_src <= tab[i][14:12];
         i_deliv_sw <= tab[i][8];
         ex(tab[i][19:16], tab[i][7:4]);
         ck_len(tab[i][0], tab[i][0] ? tab[i][7:4] : 4'h0);
      end
   endtask

   task automatic t_inj;
      apb(1'b1, OFF_ENTRY_LEN, 32'h0000_0009);
      i_injected <= 1'b1;
      i_deliv_sw <= 1'b1;
      ex(4'h3, 4'h2);
      ck_len(1'b1, 4'h9);
      i_injected <= 1'b0;
      apb(1'b0, OFF_EXIT_LEN, ZERO_WORD);
      chk(rd, 32'h0000_0019);
      apb(1'b0, OFF_STATUS, ZERO_WORD);
      chk({31'h0, rd[STAT_INJ_BIT]}, 32'h0000_0001);
   endtask

   task automatic fn(input logic [4:0] x, input logic [31:0] arg,
                     input logic p, input logic f);
      i_func_index <= x;
      i_func_arg <= arg;
      i_ptr_valid <= p;
      ex(4'h7, 4'h4);
      ck_len(f, f ? 4'h4 : 4'h0);
      chk({31'h0, o_func_fail}, {31'h0, f});
   endtask

   task automatic t_func;
      apb(1'b1, OFF_FUNC_EN, 32'h0000_0005);
      fn(5'h02, ZERO_WORD, 1'b1, 1'b0);
      fn(5'h03, ZERO_WORD, 1'b1, 1'b1);
      fn(5'h00, 32'h0000_01FF, 1'b1, 1'b0);
      fn(5'h00, FUNC_ARG_LIMIT, 1'b1, 1'b1);
      fn(5'h00, ZERO_WORD, 1'b0, 1'b1);
      apb(1'b1, OFF_FUNC_EN, ZERO_WORD);
      fn(5'h00, ZERO_WORD, 1'b1, 1'b1);
      apb(1'b1, OFF_FUNC_EN, FUNC_EN_RST);
   endtask

   // id, invalid flags, expected word
   task automatic t_info;
      logic [39:0] tab [8] = '{40'h00_0000_0100, 40'h10_0001_8100,
         40'h20_F625_8103, 40'h30_F625_8103, 40'h40_F625_8103,
         40'h50_0625_8903, 40'h22_F641_8100, 40'h43_F841_8100};
      foreach (tab[i]) begin
         i_insn_id <= tab[i][38:36];
         i_index_inv <= tab[i][33];
         i_base_inv <= tab[i][32];
         ex(4'h0, 4'h3);
         chk(o_exit_info, tab[i][31:0]);
         chk({31'h0, o_exit_info_valid}, 32'h0000_0001);
      end
      apb(1'b0, OFF_EXIT_INFO, ZERO_WORD);
      chk(rd, 32'hF841_8100);
      i_insn_id <= 3'h6;
      ex(4'h0, 4'h3);
      chk({31'h0, o_exit_info_valid}, ZERO_WORD);
   endtask

   task automatic t_hold;
      apb(1'b1, OFF_CTRL, ZERO_WORD);
      i_insn_id <= 3'h1;
      ex(4'h1, 4'h9);
      ck_len(1'b1, 4'h3);
      apb(1'b1, OFF_CTRL, CTRL_RST);
   endtask

   initial begin
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_regs;
      t_len;
      t_inj;
      t_func;
      t_info;
      t_hold;
      end_sim;
   end

   initial begin
      repeat (3000) @(posedge i_clk);
      err_total++;
      end_sim;
   end
endmodule
